// ===== logic/isl_pkg.sv
// Purpose: constants for the four-instruction decode/execute slice
// Assumes: 14-bit instruction words, 8-bit data path, 7-bit file address
// Notes: opcode patterns are matched on the upper bits only
// Summary of operation
// - pattern 00 1111 d fffffff adds one to the register, no flag change.
// - increment_skip_zero skips the next instruction when the sum is zero.
// - a taken skip squashes the fetched word and runs an idle cycle.
// - target_select 0 writes accum_reg, 1 writes the addressed register.
// - pattern 00 0100 d fffffff ORs accum_reg with the register, sets Z.
// - pattern 11 00xx kkkkkkkk copies the literal into accum_reg.
// - the two don't-care bits of load_literal_acc are ignored.
// - or_literal_into_acc ORs accum_reg with an 8-bit literal into it.
// - pattern 11 1000 kkkkkkkk is or_literal_into_acc, sets Z, one cycle.
package isl_pkg;
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int DSEL_BIT = 7;
  localparam logic [5:0] OPC_INCSKZ = 6'h0F;
  localparam logic [5:0] OPC_ORREG = 6'h04;
  localparam logic [3:0] OPC_LDLIT = 4'hC;
  localparam logic [5:0] OPC_ORLIT = 6'h38;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [DATA_W-1:0] ONE = 8'h01;
  localparam logic [DATA_W-1:0] ZERO = 8'h00;
  typedef enum logic [4:0] {
    OP_NONE = 5'h01,
    OP_INCSKZ = 5'h02,
    OP_ORREG = 5'h04,
    OP_LDLIT = 5'h08,
    OP_ORLIT = 5'h10
  } isl_op_t;
  typedef enum logic [1:0] {
    ST_RUN = 2'h1,
    ST_IDLE = 2'h2
  } isl_state_t;
endpackage : isl_pkg

// ===== logic/isl_decode.sv
// Purpose: classify an instruction word into one of four operations, or OP_NONE when no pattern matches
// Assumes: word is stable in the cycle it is presented
// Notes: purely combinational
`timescale 1ns/1ps
module isl_decode
  import isl_pkg::*;
(
  // instruction
  input wire logic [INSN_W-1:0] insn,
  // result
  output isl_op_t op
);
  always_comb begin
    if (insn[13:8] == OPC_INCSKZ) begin
      op = OP_INCSKZ;
    end else if (insn[13:8] == OPC_ORREG) begin
      op = OP_ORREG;
    end else if (insn[13:10] == OPC_LDLIT) begin
      op = OP_LDLIT;
    end else if (insn[13:8] == OPC_ORLIT) begin
      op = OP_ORLIT;
    end else begin
      op = OP_NONE;
    end
  end
endmodule : isl_decode

// ===== logic/isl_exec.sv
// Purpose: execute increment-skip, OR and load-literal instructions
// Assumes: file register read data is valid combinationally for reg_addr
// Notes: one instruction per enabled cycle; accumulator and Z held here
`timescale 1ns/1ps
module isl_exec
  import isl_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // instruction issue
  input wire logic insn_valid,
  input wire logic [INSN_W-1:0] insn,
  // file register port
  output logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_rdata,
  output logic reg_we,
  output logic [DATA_W-1:0] reg_wdata,
  // core state
  output logic [DATA_W-1:0] accum_q,
  output logic result_nil_flag_q,
  output logic skip_idle,
  output logic busy_idle
);
  isl_op_t op;
  isl_state_t state_q;
  isl_state_t state_d;
  logic exec;
  logic [DATA_W-1:0] result;
  logic dest_reg;
  logic skip_take;
  logic z_upd;
  logic acc_wr;
  logic [DATA_W-1:0] lit;

  ////////////////////////////////////////////////////////////////////////
  // decode
  isl_decode u_dec (
    .insn(insn),
    .op(op)
  );

  assign exec = ce && insn_valid && (state_q == ST_RUN);
  assign lit = insn[DATA_W-1:0];
  assign reg_addr = insn[ADDR_W-1:0];
  assign dest_reg = insn[DSEL_BIT];

  ////////////////////////////////////////////////////////////////////////
  // datapath
  always_comb begin
    result = ZERO;
    z_upd = 1'b0;
    acc_wr = 1'b0;
    reg_we = 1'b0;
    skip_take = 1'b0;
    case (op)
      OP_INCSKZ: begin
        result = reg_rdata + ONE;
        skip_take = (result == ZERO);
        acc_wr = !dest_reg;
        reg_we = dest_reg;
      end
      OP_ORREG: begin
        result = accum_q | reg_rdata;
        z_upd = 1'b1;
        acc_wr = !dest_reg;
        reg_we = dest_reg;
      end
      OP_LDLIT: begin
        result = lit;
        acc_wr = 1'b1;
      end
      OP_ORLIT: begin
        result = accum_q | lit;
        z_upd = 1'b1;
        acc_wr = 1'b1;
      end
      default: begin
        result = ZERO;
      end
    endcase
    if (!exec) begin
      acc_wr = 1'b0;
      reg_we = 1'b0;
      z_upd = 1'b0;
      skip_take = 1'b0;
    end
  end
  assign reg_wdata = result;

  ////////////////////////////////////////////////////////////////////////
  // accumulator
  always_ff @(posedge clk) begin
    if (rst) begin
      accum_q <= ACC_RST;
    end else if (ce && acc_wr) begin
      accum_q <= result;
    end
  end

  // zero flag
  always_ff @(posedge clk) begin
    if (rst) begin
      result_nil_flag_q <= 1'b0;
    end else if (ce && z_upd) begin
      result_nil_flag_q <= (result == ZERO);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // skip sequencing: squash next fetched word
  always_comb begin
    case (state_q)
      ST_RUN: state_d = skip_take ? ST_IDLE : ST_RUN;
      ST_IDLE: state_d = ST_RUN;
      default: state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_RUN;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  assign skip_idle = skip_take;
  assign busy_idle = (state_q == ST_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_inc_value;
    @(posedge clk) disable iff (rst)
      exec && op == OP_INCSKZ |-> reg_wdata == reg_rdata + ONE;
  endproperty
  a_inc_value: assert property (p_inc_value)
    else $error("increment result wrong");

  property p_inc_noflag;
    @(posedge clk) disable iff (rst)
      ce && exec && op == OP_INCSKZ |=> $stable(result_nil_flag_q);
  endproperty
  a_inc_noflag: assert property (p_inc_noflag)
    else $error("increment changed zero flag");

  property p_skip;
    @(posedge clk) disable iff (rst)
      ce && exec && op == OP_INCSKZ && reg_rdata == 8'hFF |=> busy_idle;
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip not taken on zero");

  property p_noskip;
    @(posedge clk) disable iff (rst)
      ce && exec && op == OP_INCSKZ && reg_rdata != 8'hFF |=> !busy_idle;
  endproperty
  a_noskip: assert property (p_noskip)
    else $error("skip taken on nonzero");

  property p_idle;
    @(posedge clk) disable iff (rst)
      busy_idle |-> !reg_we && !acc_wr && !z_upd;
  endproperty
  a_idle: assert property (p_idle)
    else $error("squashed word had effect");

  property p_idle_one;
    @(posedge clk) disable iff (rst)
      ce && busy_idle |=> !busy_idle;
  endproperty
  a_idle_one: assert property (p_idle_one)
    else $error("idle cycle lasted too long");

  property p_dest;
    @(posedge clk) disable iff (rst)
      exec && (op == OP_ORREG || op == OP_INCSKZ)
        |-> reg_we == dest_reg && acc_wr == !dest_reg;
  endproperty
  a_dest: assert property (p_dest)
    else $error("wrong destination");

  property p_orreg;
    @(posedge clk) disable iff (rst)
      ce && exec && op == OP_ORREG && !dest_reg
        |=> accum_q == ($past(accum_q) | $past(reg_rdata))
            && result_nil_flag_q == (accum_q == ZERO);
  endproperty
  a_orreg: assert property (p_orreg)
    else $error("or with register wrong");

  property p_ldlit;
    @(posedge clk) disable iff (rst)
      ce && exec && op == OP_LDLIT
        |=> accum_q == $past(lit) && $stable(result_nil_flag_q);
  endproperty
  a_ldlit: assert property (p_ldlit)
    else $error("load literal wrong");

  property p_dontcare;
    @(posedge clk) disable iff (rst)
      insn[13:10] == OPC_LDLIT |-> op == OP_LDLIT;
  endproperty
  a_dontcare: assert property (p_dontcare)
    else $error("don't care bits affect decode");

  property p_orlit;
    @(posedge clk) disable iff (rst)
      ce && exec && op == OP_ORLIT
        |=> accum_q == ($past(accum_q) | $past(lit))
            && result_nil_flag_q == (accum_q == ZERO);
  endproperty
  a_orlit: assert property (p_orlit)
    else $error("or literal wrong");

  property p_orlit_dec;
    @(posedge clk) disable iff (rst)
      insn[13:8] == OPC_ORLIT |-> op == OP_ORLIT;
  endproperty
  a_orlit_dec: assert property (p_orlit_dec)
    else $error("or literal not decoded");

  property p_zflag;
    @(posedge clk) disable iff (rst)
      ce && z_upd |=> result_nil_flag_q == ($past(result) == ZERO);
  endproperty
  a_zflag: assert property (p_zflag)
    else $error("zero flag wrong");

  c_skip: cover property (@(posedge clk) disable iff (rst)
    skip_take ##1 busy_idle);
  c_orreg_f: cover property (@(posedge clk) disable iff (rst)
    exec && op == OP_ORREG && dest_reg);
  c_orlit_z: cover property (@(posedge clk) disable iff (rst)
    exec && op == OP_ORLIT && result == ZERO);
  c_ldlit_x: cover property (@(posedge clk) disable iff (rst)
    exec && op == OP_LDLIT && insn[9:8] != 2'h0);
endmodule : isl_exec

// ===== test/tb.sv
// Purpose: self-checking bench for the decode/execute slice
// Assumes: tb is the top module and isl_exec the device under test; file register modelled by reg_rdata
// Notes: rows chain the accumulator; skip, ce and reset tested by hand
`timescale 1ns/1ps
module tb;
  import isl_pkg::*;
  typedef struct packed {
    logic [13:0] insn;
    logic [7:0] rd;
    logic we;
    logic [7:0] wd;
    logic sk;
    logic [7:0] acc;
    logic z;
  } isl_row_t;
  logic clk, rst, ce, insn_valid, reg_we, result_nil_flag_q;
  logic skip_idle, busy_idle;
  logic [INSN_W-1:0] insn;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_rdata, reg_wdata, accum_q;
  int mismatches, compares;
  isl_row_t rows [11];
  //////////////////////////////////////////////////////////////////////////
  isl_exec dut (.clk(clk), .rst(rst), .ce(ce), .insn_valid(insn_valid),
    .insn(insn), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .reg_we(reg_we), .reg_wdata(reg_wdata), .accum_q(accum_q),
    .result_nil_flag_q(result_nil_flag_q), .skip_idle(skip_idle),
    .busy_idle(busy_idle));
  always #5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string what);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    rows[0] = '{14'h309A, 8'h00, 1'b0, 8'h00, 1'b0, 8'h9A, 1'b0};
    rows[1] = '{14'h3835, 8'h00, 1'b0, 8'h00, 1'b0, 8'hBF, 1'b0};
    rows[2] = '{14'h3300, 8'h00, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0};
    rows[3] = '{14'h3800, 8'h00, 1'b0, 8'h00, 1'b0, 8'h00, 1'b1};
    rows[4] = '{14'h0F05, 8'h05, 1'b0, 8'h00, 1'b0, 8'h06, 1'b1};
    rows[5] = '{14'h3291, 8'h00, 1'b0, 8'h00, 1'b0, 8'h91, 1'b1};
    rows[6] = '{14'h0405, 8'h13, 1'b0, 8'h00, 1'b0, 8'h93, 1'b0};
    rows[7] = '{14'h04A2, 8'h0C, 1'b1, 8'h9F, 1'b0, 8'h93, 1'b0};
    rows[8] = '{14'h0F91, 8'h41, 1'b1, 8'h42, 1'b0, 8'h93, 1'b0};
    rows[9] = '{14'h3000, 8'h00, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0};
    rows[10] = '{14'h04C0, 8'h00, 1'b1, 8'h00, 1'b0, 8'h00, 1'b1};
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    insn_valid = 1'b0;
    insn = '0;
    reg_rdata = '0;
    repeat (4) @(posedge clk);
    #1;
    chk(accum_q, 8'h00, "acc reset");
    chk(result_nil_flag_q, 1'b0, "flag reset");
    @(negedge clk);
    rst = 1'b0;
    insn_valid = 1'b1;
    for (int i = 0; i < 11; i++) begin
      if (i > 0) @(negedge clk);
      insn = rows[i].insn;
      reg_rdata = rows[i].rd;
      #1;
      chk(reg_we, rows[i].we, "write");
      if (rows[i].we) chk(reg_wdata, rows[i].wd, "wdata");
      chk({1'b0, reg_addr}, {1'b0, rows[i].insn[6:0]}, "addr");
      chk(skip_idle, rows[i].sk, "skip");
      @(posedge clk);
      #1;
      chk(accum_q, rows[i].acc, "acc");
      chk(result_nil_flag_q, rows[i].z, "flag");
    end
    $display("test rows done");
    @(negedge clk);
    insn = 14'h0F10;
    reg_rdata = 8'hFF;
    #1;
    chk(skip_idle, 1'b1, "skip taken");
    chk(reg_we, 1'b0, "skip write");
    @(posedge clk);
    #1;
    chk(accum_q, 8'h00, "skip acc");
    chk(result_nil_flag_q, 1'b1, "skip flag");
    chk(busy_idle, 1'b1, "idle slot");
    @(negedge clk);
    insn = 14'h0481;
    reg_rdata = 8'h01;
    #1;
    chk(reg_we, 1'b0, "squashed write");
    @(posedge clk);
    #1;
    chk(accum_q, 8'h00, "squashed acc");
    chk(result_nil_flag_q, 1'b1, "squashed flag");
    chk(busy_idle, 1'b0, "idle over");
    $display("test skip done");
    @(negedge clk);
    ce = 1'b0;
    insn = 14'h3877;
    #1;
    chk(reg_we, 1'b0, "ce write");
    @(posedge clk);
    #1;
    chk(accum_q, 8'h00, "ce acc");
    @(negedge clk);
    ce = 1'b1;
    @(posedge clk);
    #1;
    chk(accum_q, 8'h77, "ce resume");
    chk(result_nil_flag_q, 1'b0, "ce flag");
    $display("test ce done");
    @(negedge clk);
    rst = 1'b1;
    @(posedge clk);
    #1;
    chk(accum_q, 8'h00, "rerst acc");
    chk(result_nil_flag_q, 1'b0, "rerst flag");
    $display("test reset done");
    report_and_stop();
  end
endmodule : tb
